//--- hdl/pwm_chan.v
// Purpose: one standalone 16-bit pwm channel, repeat or one-shot, avalon-mm registers
// Assumes: 50 MHz MCLK_I; pwm tick is an enable pulse standing for a falling pwm clock edge
// Notes: external trigger pins pass two flip-flops before use
//
// The implementer's own choices: register access over Avalon-MM and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_chan_defs.vh"
// Contract
// - run set: status rises at first tick, counting starts at second tick
// - counter equal to duty shadow drops output flag at next tick
// - repeat mode period match sets flag, zeroes counter, keeps counting
// - every period match reloads duty and period shadows from settings
// - after run clears, count one more tick, then halt and drop status
// - run set again resumes from held counter value without clearing
// - writing either counter byte zeroes counter and sets output flag high
// - while stopped with run clear, setting writes pass straight into the shadows
// - tick clock source chosen by fields of control registers 0 and 6
// - interrupt point and output polarity chosen in control register 0
// - external pin may start, stop or clear counter per mode fields
// - period equals period setting plus one ticks
// - first-half duty equals duty setting plus one ticks
// - first interrupt may lag one tick; later ones come at fixed period
// - interrupt may still fire during the extra tick after run clears
// - uncoupled channel; mode bit zero repeat, one one-shot
// - in one-shot, software sets run again for another cycle
// - one-shot period match zeroes counter, stops, and clears run itself
module pwm_chan
(
	input wire MCLK_I,
	input wire NRST_I,
	input wire [5:0] AVS_ADDRESS_I,
	input wire AVS_READ_I,
	input wire AVS_WRITE_I,
	input wire [31:0] AVS_WRITEDATA_I,
	output reg [31:0] AVS_READDATA_O,
	output reg AVS_WAITREQUEST_O,
	input wire TRIG0_I,
	input wire TRIG1_I,
	output reg PWM_O,
	output reg CHANNEL_INTERRUPT_O
);
	reg [15:0] counter_reg;
	reg [15:0] duty_setting_reg;
	reg [15:0] period_setting_reg;
	reg [15:0] duty_shadow_reg;
	reg [15:0] period_shadow_reg;
	reg [7:0] ctl0_reg;
	reg [7:0] ctl2_reg;
	reg [7:0] ctl6_reg;
	reg run_bit_reg;
	reg oneshot_select_reg;
	reg pair_coupling_select_reg;
	reg count_active_status_reg;
	reg output_level_flag_reg;
	reg [7:0] div_reg;
	reg [2:0] trig_sync0_reg;
	reg [2:0] trig_sync1_reg;
	reg ack_reg;
	wire bus_req;
	wire wr_fire;
	wire cnt_wr;
	wire hw_run_clear;
	wire irq_at_period;
	wire pol_invert;
	wire pwm_tick_clock;
	wire trig_level;
	wire trig_prev;
	wire [1:0] start_mode;
	wire [1:0] trig_edge;
	wire start_lvl;
	wire edge_start;
	wire edge_stop;
	wire ext_allow;
	wire ext_clear;
	wire ext_stop;
	wire stopped;
	wire duty_match;
	wire period_match;
	wire [7:0] div_limit;
	reg [7:0] div_limit_sel;
	reg irq_event_reg;

	function is_addr;
		input [5:0] a;
		input [5:0] ofs;
		begin
			is_addr = (a == ofs);
		end
	endfunction

	assign bus_req = AVS_READ_I | AVS_WRITE_I;
	assign wr_fire = AVS_WRITE_I & ack_reg;
	// counter byte write: zero the count, flag high, ahead of any tick
	assign cnt_wr = wr_fire & (is_addr(AVS_ADDRESS_I, `OFS_CNT_LO) |
		is_addr(AVS_ADDRESS_I, `OFS_CNT_HI));
	assign irq_at_period = ctl0_reg[`CTL0_IP_LSB];
	assign pol_invert = ctl0_reg[`CTL0_POL_BIT];

	// tick divider: ctl0 selects base rate; its setting 3 takes the whole divide from ctl6 instead
	always @*
	begin
		case (ctl0_reg[`CTL0_CS_LSB +: 2])
			2'h0: div_limit_sel = 8'h00;
			2'h1: div_limit_sel = `CS_LIM_4;
			2'h2: div_limit_sel = `CS_LIM_16;
			default: div_limit_sel = ctl6_reg[`CTL6_DIV_LSB +: 8];
		endcase
	end
	assign div_limit = div_limit_sel;
	// a limit lowered below the running count ends the tick period at once
	assign pwm_tick_clock = (div_reg >= div_limit);

	always @(posedge MCLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			div_reg <= 8'h00;
		else if (pwm_tick_clock)
			div_reg <= 8'h00;
		else
			div_reg <= div_reg + 8'h01;
	end

	// trigger synchronisers; stage 0 feeds only stage 1
	always @(posedge MCLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			trig_sync0_reg <= 3'h0;
			trig_sync1_reg <= 3'h0;
		end
		else
		begin
			trig_sync0_reg <= {trig_sync0_reg[1:0], TRIG0_I};
			trig_sync1_reg <= {trig_sync1_reg[1:0], TRIG1_I};
		end
	end

	assign start_mode = ctl2_reg[`CTL2_STM_LSB +: 2];
	assign trig_edge = ctl2_reg[`CTL2_TGE_LSB +: 2];
	assign trig_level = ctl2_reg[`CTL2_TGSEL_BIT] ? trig_sync1_reg[1] : trig_sync0_reg[1];
	assign trig_prev = ctl2_reg[`CTL2_TGSEL_BIT] ? trig_sync1_reg[2] : trig_sync0_reg[2];
	assign start_lvl = trig_edge[1] ? ~trig_level : trig_level;
	assign edge_start = start_lvl & ~(trig_edge[1] ? ~trig_prev : trig_prev);
	assign edge_stop = ~start_lvl & (trig_edge[1] ? ~trig_prev : trig_prev);
	// mode 1 gates by level, mode 2 starts on edge and stops on edge
	assign ext_allow = (start_mode == 2'h1) ? start_lvl : 1'b1;
	assign ext_stop = ((start_mode == 2'h1) | (start_mode == 2'h2)) & edge_stop;
	assign ext_clear = ((start_mode == 2'h3) & (edge_start | edge_stop)) | ext_stop;

	// edge start mode arms on the start edge, disarms on stop or run clear
	reg ext_armed_reg;
	always @(posedge MCLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
			ext_armed_reg <= 1'b0;
		else if (start_mode != 2'h2 || !run_bit_reg || ext_stop)
			ext_armed_reg <= 1'b0;
		else if (edge_start)
			ext_armed_reg <= 1'b1;
	end

	// software run bit gated by the start mode's level or edge arming
	wire go;
	assign go = run_bit_reg & ext_allow & ((start_mode == 2'h2) ? ext_armed_reg : 1'b1);
	// shadow direct writes need run clear and the count fully stopped
	assign stopped = ~count_active_status_reg;
	assign duty_match = (counter_reg == duty_shadow_reg);
	assign period_match = (counter_reg == period_shadow_reg);
	// one-shot end clears run and beats a software write of the same cycle
	assign hw_run_clear = pwm_tick_clock & count_active_status_reg & ~cnt_wr & ~ext_clear &
		oneshot_select_reg & period_match;

	// count state, flags and shadows
	always @(posedge MCLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			counter_reg <= 16'h0000;
			duty_shadow_reg <= `RST_DUTY;
			period_shadow_reg <= `RST_PER;
			count_active_status_reg <= 1'b0;
			output_level_flag_reg <= 1'b1;
			irq_event_reg <= 1'b0;
		end
		else
		begin
			irq_event_reg <= 1'b0;
			if (cnt_wr)
			begin
				counter_reg <= 16'h0000;
				output_level_flag_reg <= 1'b1;
			end
			else if (ext_clear)
			begin
				counter_reg <= 16'h0000;
				output_level_flag_reg <= 1'b1;
				duty_shadow_reg <= duty_setting_reg;
				period_shadow_reg <= period_setting_reg;
			end
			else if (pwm_tick_clock)
			begin
				if (!count_active_status_reg)
					count_active_status_reg <= go;
				else
				begin
					// counting edge, also the one extra edge after stop
					if (period_match)
					begin
						output_level_flag_reg <= 1'b1;
						counter_reg <= 16'h0000;
						duty_shadow_reg <= duty_setting_reg;
						period_shadow_reg <= period_setting_reg;
						if (irq_at_period)
							irq_event_reg <= 1'b1;
					end
					else
					begin
						counter_reg <= counter_reg + 16'h0001;
						if (duty_match)
						begin
							output_level_flag_reg <= 1'b0;
							if (!irq_at_period)
								irq_event_reg <= 1'b1;
						end
					end
					if (!go || (oneshot_select_reg && period_match))
						count_active_status_reg <= 1'b0;
				end
			end
			if (wr_fire && stopped && !run_bit_reg)
			begin
				if (is_addr(AVS_ADDRESS_I, `OFS_DUTY_LO))
					duty_shadow_reg[7:0] <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_DUTY_HI))
					duty_shadow_reg[15:8] <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_PER_LO))
					period_shadow_reg[7:0] <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_PER_HI))
					period_shadow_reg[15:8] <= AVS_WRITEDATA_I[7:0];
			end
		end
	end

	// software registers; hardware clear of run wins in one-shot
	always @(posedge MCLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			duty_setting_reg <= `RST_DUTY;
			period_setting_reg <= `RST_PER;
			ctl0_reg <= 8'h00;
			ctl2_reg <= 8'h00;
			ctl6_reg <= 8'h00;
			run_bit_reg <= 1'b0;
			oneshot_select_reg <= 1'b0;
			pair_coupling_select_reg <= 1'b0;
		end
		else
		begin
			if (wr_fire)
			begin
				if (is_addr(AVS_ADDRESS_I, `OFS_DUTY_LO))
					duty_setting_reg[7:0] <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_DUTY_HI))
					duty_setting_reg[15:8] <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_PER_LO))
					period_setting_reg[7:0] <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_PER_HI))
					period_setting_reg[15:8] <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_CTL0))
					ctl0_reg <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_CTL2))
					ctl2_reg <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_CTL6))
					ctl6_reg <= AVS_WRITEDATA_I[7:0];
				if (is_addr(AVS_ADDRESS_I, `OFS_CTL1))
				begin
					run_bit_reg <= AVS_WRITEDATA_I[`CTL1_RUN_BIT];
					oneshot_select_reg <= AVS_WRITEDATA_I[`CTL1_MD_BIT];
					pair_coupling_select_reg <= AVS_WRITEDATA_I[`CTL1_CPL_BIT];
				end
			end
			if (hw_run_clear)
				run_bit_reg <= 1'b0;
		end
	end

	// avalon slave: one wait cycle, then ack
	always @(posedge MCLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			ack_reg <= 1'b0;
			AVS_WAITREQUEST_O <= 1'b1;
			AVS_READDATA_O <= 32'h00000000;
		end
		else
		begin
			ack_reg <= bus_req & ~ack_reg;
			AVS_WAITREQUEST_O <= ~(bus_req & ~ack_reg);
			// only reads move read data, so they stand until the next read
			if (AVS_READ_I && !ack_reg)
			begin
				case (AVS_ADDRESS_I)
					`OFS_CNT_LO: AVS_READDATA_O <= {24'h000000, counter_reg[7:0]};
					`OFS_CNT_HI: AVS_READDATA_O <= {24'h000000, counter_reg[15:8]};
					`OFS_DUTY_LO: AVS_READDATA_O <= {24'h000000, duty_setting_reg[7:0]};
					`OFS_DUTY_HI: AVS_READDATA_O <= {24'h000000, duty_setting_reg[15:8]};
					`OFS_PER_LO: AVS_READDATA_O <= {24'h000000, period_setting_reg[7:0]};
					`OFS_PER_HI: AVS_READDATA_O <= {24'h000000, period_setting_reg[15:8]};
					`OFS_CTL0: AVS_READDATA_O <= {24'h000000, ctl0_reg};
					`OFS_CTL1: AVS_READDATA_O <= {28'h0000000, pair_coupling_select_reg,
						oneshot_select_reg, count_active_status_reg, run_bit_reg};
					`OFS_CTL2: AVS_READDATA_O <= {24'h000000, ctl2_reg};
					`OFS_CTL6: AVS_READDATA_O <= {24'h000000, ctl6_reg};
					`OFS_DBUF_LO: AVS_READDATA_O <= {24'h000000, duty_shadow_reg[7:0]};
					`OFS_DBUF_HI: AVS_READDATA_O <= {24'h000000, duty_shadow_reg[15:8]};
					`OFS_PBUF_LO: AVS_READDATA_O <= {24'h000000, period_shadow_reg[7:0]};
					`OFS_PBUF_HI: AVS_READDATA_O <= {24'h000000, period_shadow_reg[15:8]};
					default: AVS_READDATA_O <= 32'h00000000;
				endcase
			end
		end
	end

	// pin outputs
	always @(posedge MCLK_I or negedge NRST_I)
	begin
		if (!NRST_I)
		begin
			PWM_O <= 1'b0;
			CHANNEL_INTERRUPT_O <= 1'b0;
		end
		else
		begin
			PWM_O <= output_level_flag_reg ^ pol_invert;
			CHANNEL_INTERRUPT_O <= irq_event_reg;
		end
	end
endmodule
`default_nettype wire

//--- hdl/pwm_chan_defs.vh
// Purpose: constants for the single pwm channel
// Assumes: byte-wide registers, one per aligned avalon word
// Notes: offsets are byte addresses
`ifndef PWM_CHAN_DEFS_VH
`define PWM_CHAN_DEFS_VH
`define OFS_CNT_LO 6'h00
`define OFS_CNT_HI 6'h04
`define OFS_DUTY_LO 6'h08
`define OFS_DUTY_HI 6'h0c
`define OFS_PER_LO 6'h10
`define OFS_PER_HI 6'h14
`define OFS_CTL0 6'h18
`define OFS_CTL1 6'h1c
`define OFS_CTL2 6'h20
`define OFS_CTL6 6'h24
`define OFS_DBUF_LO 6'h28
`define OFS_DBUF_HI 6'h2c
`define OFS_PBUF_LO 6'h30
`define OFS_PBUF_HI 6'h34
`define CTL0_CS_LSB 0
`define CTL0_POL_BIT 2
`define CTL0_IP_LSB 3
`define CTL1_RUN_BIT 0
`define CTL1_STAT_BIT 1
`define CTL1_MD_BIT 2
`define CTL1_CPL_BIT 3
`define CTL2_STM_LSB 0
`define CTL2_TGE_LSB 2
`define CTL2_TGSEL_BIT 4
`define CTL6_DIV_LSB 0
`define CS_LIM_4 8'h03
`define CS_LIM_16 8'h0f
`define RST_DUTY 16'h0000
`define RST_PER 16'hffff
`endif

//--- tb/pwm_chan_chk.sv
// Purpose: port-level checks of the pwm channel
// Assumes: bound to pwm_chan, one clock domain
// Notes: bus checks follow the one-wait-state handshake
`timescale 1ns/1ps
`default_nettype none
module pwm_chan_chk
(
	input wire logic MCLK_I,
	input wire logic NRST_I,
	input wire logic AVS_READ_I,
	input wire logic AVS_WRITE_I,
	input wire logic [31:0] AVS_READDATA_O,
	input wire logic AVS_WAITREQUEST_O,
	input wire logic PWM_O,
	input wire logic CHANNEL_INTERRUPT_O
);
	wire req = AVS_READ_I | AVS_WRITE_I;
	default clocking cb @(posedge MCLK_I); endclocking
	default disable iff (!NRST_I);
	a_wait_one_state: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
		else $error("no answer one cycle after request");
	a_ack_one_cycle: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
		else $error("waitrequest low longer than one cycle");
	a_idle_no_ack: assert property (!req |=> AVS_WAITREQUEST_O)
		else $error("answer without request");
	a_rdata_upper_zero: assert property (AVS_READDATA_O[31:8] == 24'h000000)
		else $error("upper read data bits not zero");
	a_rdata_hold: assert property (!$stable(AVS_READDATA_O) |-> !AVS_WAITREQUEST_O && AVS_READ_I)
		else $error("read data changed outside a read answer");
	a_irq_pulse: assert property (CHANNEL_INTERRUPT_O |=> !CHANNEL_INTERRUPT_O)
		else $error("interrupt longer than one cycle");
	a_flag_init_high: assert property ($rose(NRST_I) |=> PWM_O ##1 PWM_O)
		else $error("output not high after reset");
	a_reset_quiet: assert property (disable iff (1'b0) !NRST_I |=> !PWM_O && !CHANNEL_INTERRUPT_O && AVS_WAITREQUEST_O)
		else $error("outputs active during reset");
endmodule
bind pwm_chan pwm_chan_chk u_chk(.MCLK_I(MCLK_I), .NRST_I(NRST_I), .AVS_READ_I(AVS_READ_I),
	.AVS_WRITE_I(AVS_WRITE_I), .AVS_READDATA_O(AVS_READDATA_O),
	.AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .PWM_O(PWM_O),
	.CHANNEL_INTERRUPT_O(CHANNEL_INTERRUPT_O));
`default_nettype wire

//--- tb/pwm_pins_model.sv
// Purpose: far side of the channel: trigger pins and output measurement
// Assumes: trigger pins idle low and follow the bench's drive request
// Notes: lengths are in clock cycles, latched on each edge of the output
`timescale 1ns/1ps
`default_nettype none
module pwm_pins_model
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic pwm,
	input wire logic [1:0] drive,
	output logic trig0,
	output logic trig1,
	output logic [15:0] high_len,
	output logic [15:0] per_len
);
	logic [15:0] hc;
	logic [15:0] pc;
	logic last;
	// trigger pins follow the bench's request one clock later
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			{trig1, trig0} <= 2'b00;
		else
			{trig1, trig0} <= drive;
	end
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{hc, pc, high_len, per_len, last} <= '0;
		end
		else
		begin
			last <= pwm;
			pc <= (pwm && !last) ? 16'h0001 : pc + 16'h0001;
			hc <= (pwm && !last) ? 16'h0001 : hc + {15'h0000, pwm};
			if (pwm && !last)
				per_len <= pc;
			if (!pwm && last)
				high_len <= hc;
		end
	end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Purpose: self-checking bench of the pwm channel
// Assumes: tick at full clock rate except one quarter-rate check
// Notes: duty 3 and period 9 give 4 high cycles in 10
`timescale 1ns/1ps
`default_nettype none
`include "pwm_chan_defs.vh"
module tb_top;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [5:0] addr = 6'h00;
	logic rd = 1'b0;
	logic wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [1:0] drv = 2'b00;
	wire [31:0] rdata;
	wire wait_req, pwm, irq, trig0, trig1;
	wire [15:0] high_len, per_len;
	int errors = 0;
	int tests_run = 0;
	logic [7:0] q;
	logic [7:0] c1;
	int n;
	pwm_chan u_dut(.MCLK_I(clk), .NRST_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
		.AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
		.AVS_WAITREQUEST_O(wait_req), .TRIG0_I(trig0), .TRIG1_I(trig1), .PWM_O(pwm),
		.CHANNEL_INTERRUPT_O(irq));
	pwm_pins_model u_pins(.clk(clk), .rst_n(rst_n), .pwm(pwm), .drive(drv), .trig0(trig0),
		.trig1(trig1),
		.high_len(high_len), .per_len(per_len));
	initial
	begin
		forever #10 clk = ~clk;
	end
	task automatic end_sim();
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
		tests_run++;
		if (got !== exp)
		begin
			errors++;
			$display("unexpected at %0t: %s got %h", $time, m, got);
		end
	endtask
	task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk);
		addr <= a;
		wr <= w;
		rd <= !w;
		wdata <= {24'h000000, d};
		do begin @(posedge clk); k++; end while (wait_req !== 1'b0 && k < 50);
		q = rdata[7:0];
		if (k >= 50)
			chk(1'b1, 1'b0, "bus timeout");
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	task automatic wait_irq();
		n = 0;
		do begin @(posedge clk); n++; end while (irq !== 1'b1 && n < 400);
	endtask
	task automatic t_reset_regs();
		bus(0, `OFS_DBUF_HI, 0); chk(q, `RST_DUTY >> 8, "duty shadow reset");
		bus(0, `OFS_PBUF_LO, 0); chk(q, `RST_PER & 16'hff, "period shadow reset");
		bus(0, 6'h38, 0); chk(q, 0, "unmapped read");
	endtask
	task automatic t_stopped_load();
		bus(1, `OFS_DUTY_LO, 3); bus(1, `OFS_DUTY_HI, 0);
		bus(1, `OFS_PER_LO, 9); bus(1, `OFS_PER_HI, 0);
		bus(0, `OFS_DBUF_LO, 0); chk(q, 3, "duty direct load");
		bus(0, `OFS_PBUF_LO, 0); chk(q, 9, "period direct load");
	endtask
	task automatic t_repeat();
		bus(1, `OFS_CTL0, 8'h08);
		bus(1, `OFS_CTL1, 8'h01);
		wait_irq(); wait_irq(); chk(n, 10, "interrupt spacing");
		bus(1, `OFS_DUTY_LO, 5);
		bus(0, `OFS_DBUF_LO, 0); chk(q, 3, "shadow kept mid period");
		wait_irq(); wait_irq();
		chk(per_len, 10, "output period");
		chk(high_len, 6, "output high time");
		bus(0, `OFS_DBUF_LO, 0); chk(q, 5, "shadow reload at match");
		bus(1, `OFS_CTL0, 8'h09);
		wait_irq(); wait_irq(); chk(n, 40, "interrupt spacing at quarter rate");
		bus(1, `OFS_CTL0, 8'h08);
	endtask
	task automatic t_stop_resume();
		bus(1, `OFS_CTL1, 8'h00);
		n = 0;
		do begin bus(0, `OFS_CTL1, 0); n++; end while (q[1] !== 1'b0 && n < 20);
		chk(q[1], 0, "status drops after stop");
		bus(1, `OFS_CNT_HI, 0); bus(1, `OFS_PER_LO, 8'h40);
		bus(0, `OFS_CNT_LO, 0); chk(q, 0, "counter write clears");
		chk(pwm, 1, "flag high after counter write");
		bus(1, `OFS_CTL1, 8'h01); bus(1, `OFS_CTL1, 8'h00);
		repeat (4) @(posedge clk);
		bus(0, `OFS_CNT_LO, 0); c1 = q;
		repeat (8) @(posedge clk);
		bus(0, `OFS_CNT_LO, 0); chk(q, c1, "counter held while stopped");
		bus(1, `OFS_CTL1, 8'h01); bus(1, `OFS_CTL1, 8'h00);
		repeat (4) @(posedge clk);
		bus(0, `OFS_CNT_LO, 0); chk(q > c1 && c1 > 0, 1, "resume from held count");
		bus(1, `OFS_CNT_LO, 0);
		bus(1, `OFS_CTL0, 8'h0c); @(posedge clk); @(posedge clk);
		chk(pwm, 0, "inverted polarity");
	endtask
	task automatic t_ext_clear();
		bus(1, `OFS_CTL1, 8'h01); bus(1, `OFS_CTL1, 8'h00);
		bus(1, `OFS_CTL2, 8'h07);
		drv <= 2'b01;
		repeat (6) @(posedge clk);
		bus(0, `OFS_CNT_LO, 0); chk(q, 0, "pin edge clears counter");
		drv <= 2'b00;
		bus(1, `OFS_CTL2, 8'h00);
	endtask
	task automatic t_oneshot();
		bus(1, `OFS_CTL1, 8'h05);
		n = 0;
		do begin bus(0, `OFS_CTL1, 0); n++; end while (q[0] !== 1'b0 && n < 100);
		chk(q[0], 0, "run cleared by one-shot");
		bus(0, `OFS_CNT_LO, 0); chk(q, 0, "counter zero after one-shot");
		bus(1, `OFS_CTL1, 8'h05); wait_irq(); chk(irq, 1, "second one-shot cycle");
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		t_reset_regs();
		t_stopped_load();
		t_repeat();
		t_stop_resume();
		t_ext_clear();
		t_oneshot();
		end_sim();
	end
	initial
	begin
		#400000;
		errors++;
		end_sim();
	end
endmodule
`default_nettype wire
